// file: inc/port_cfg_pkg.sv
package port_cfg_pkg;
	// special-function register addresses
	localparam logic [7:0] ADDR_PORT2_PIN_DATA = 8'hA0;
	localparam logic [7:0] ADDR_PORT1_OUTPUT_DRIVER_SELECT = 8'hA5;
	localparam logic [7:0] ADDR_PORT2_OUTPUT_DRIVER_SELECT = 8'hA6;
	localparam logic [7:0] ADDR_PORT1_CROSSBAR_BYPASS = 8'hD5;
	localparam logic [7:0] ADDR_PORT1_ANALOG_DIGITAL_SELECT = 8'hF2;
	// reset values
	localparam logic [7:0] RST_PORT2_PIN_DATA = 8'h01;
	localparam logic [7:0] RST_PORT1_OUTPUT_DRIVER_SELECT = 8'h00;
	localparam logic [7:0] RST_PORT2_OUTPUT_DRIVER_SELECT = 8'h00;
	localparam logic [7:0] RST_PORT1_CROSSBAR_BYPASS = 8'h00;
	localparam logic [7:0] RST_PORT1_ANALOG_DIGITAL_SELECT = 8'hFF;
	// field layout
	localparam int PORT1_PINS = 8;
	localparam int BYPASS_BITS = 7;
	localparam int PORT2_BIT = 0;
	localparam logic [7:0] BYPASS_MASK = 8'h7F;
	localparam logic [7:0] LOW_BIT_MASK = 8'h01;
	// mode codes
	localparam logic MODE_ANALOG = 1'b0;
	localparam logic DRV_OPEN_DRAIN = 1'b0;
	localparam logic DRV_PUSH_PULL = 1'b1;
	localparam logic BYPASS_SKIP = 1'b1;

	// special-function register access from the core
	typedef struct packed {
		logic wr;
		logic rd;
		logic bit_op;
		logic [2:0] bit_sel;
		logic bit_val;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;

	// one pin cell: output, output enable, pullup and receiver enable
	typedef struct packed {
		logic dout;
		logic oe;
		logic pullup_en;
		logic rx_en;
	} pin_ctl_t;
endpackage

// file: logic/port_cfg.sv
`timescale 1ns/1ns
// Behaviour
// - input-mode bit 0 means analog, cell off
// - bit n of mode registers steers pin n
// - output-mode ignored while pin is analog
// - digital pin: 0 open-drain, 1 push-pull
// - bypass bits 6:0 tell crossbar to skip
// - bypass bit 7 reads zero, writes ignored
// - port 2 data write loads pin latch
// - port 2 data read returns pin level
// - port 2 data supports bit set/clear/test
// - port 2 mode bit: 0 open-drain, 1 push-pull
// - port 2 mode bits 7:1 read zero
// - bus pins stay open-drain, others follow modes
module port_cfg (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	input wire port_cfg_pkg::sfr_req_t sfr_req_i,
	output logic [7:0] sfr_rdata_o,
	output logic sfr_bit_o,
	input wire logic [7:0] port1_latch_i,
	input wire logic [7:0] port1_xbar_assigned_i,
	input wire logic [7:0] port1_xbar_dout_i,
	input wire logic [7:0] port1_smbus_pin_i,
	input wire logic [7:0] port1_pad_i,
	output port_cfg_pkg::pin_ctl_t [7:0] port1_ctl_o,
	output logic [7:0] port1_rx_o,
	output logic [7:0] port1_bypass_o,
	input wire logic port2_pad_i,
	output port_cfg_pkg::pin_ctl_t port2_ctl_o
);
	import port_cfg_pkg::*;

	logic [7:0] adsel_r;
	logic [7:0] p1drv_r;
	logic [6:0] bypass_r;
	logic p2latch_r;
	logic p2drv_r;
	logic [7:0] rdata_r;
	logic bit_r;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	wire hit_p2 = sfr_req_i.addr == ADDR_PORT2_PIN_DATA;
	wire hit_p1drv = sfr_req_i.addr == ADDR_PORT1_OUTPUT_DRIVER_SELECT;
	wire hit_p2drv = sfr_req_i.addr == ADDR_PORT2_OUTPUT_DRIVER_SELECT;
	wire hit_bypass = sfr_req_i.addr == ADDR_PORT1_CROSSBAR_BYPASS;
	wire hit_adsel = sfr_req_i.addr == ADDR_PORT1_ANALOG_DIGITAL_SELECT;
	wire wr_byte = ce_i && sfr_req_i.wr && !sfr_req_i.bit_op;
	// bit set/clear only on the bit-addressable port 2 data register
	wire wr_bit0 = ce_i && sfr_req_i.wr && sfr_req_i.bit_op && hit_p2
		&& sfr_req_i.bit_sel == 3'(PORT2_BIT);

	// ----------------------------------------
	// read-back image of every register
	// ----------------------------------------
	wire [7:0] p2_view = {7'h00, port2_pad_i} & LOW_BIT_MASK;
	wire [7:0] bypass_view = {1'b0, bypass_r};
	wire [7:0] p2drv_view = {7'h00, p2drv_r};
	wire [7:0] rd_mux = hit_p2 ? p2_view :
		hit_p1drv ? p1drv_r :
		hit_p2drv ? p2drv_view :
		hit_bypass ? bypass_view :
		hit_adsel ? adsel_r : 8'h00;

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			adsel_r <= RST_PORT1_ANALOG_DIGITAL_SELECT;
			p1drv_r <= RST_PORT1_OUTPUT_DRIVER_SELECT;
			bypass_r <= RST_PORT1_CROSSBAR_BYPASS[BYPASS_BITS-1:0];
			p2latch_r <= RST_PORT2_PIN_DATA[PORT2_BIT];
			p2drv_r <= RST_PORT2_OUTPUT_DRIVER_SELECT[PORT2_BIT];
		end else begin
			if (wr_byte && hit_adsel) adsel_r <= sfr_req_i.wdata;
			if (wr_byte && hit_p1drv) p1drv_r <= sfr_req_i.wdata;
			if (wr_byte && hit_bypass) bypass_r <= sfr_req_i.wdata[BYPASS_BITS-1:0];
			if (wr_byte && hit_p2) p2latch_r <= sfr_req_i.wdata[PORT2_BIT];
			if (wr_bit0) p2latch_r <= sfr_req_i.bit_val;
			if (wr_byte && hit_p2drv) p2drv_r <= sfr_req_i.wdata[PORT2_BIT];
		end
	end

	// read data and bit-test result, registered
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rdata_r <= 8'h00;
			bit_r <= 1'b0;
		end else if (ce_i && sfr_req_i.rd) begin
			rdata_r <= rd_mux;
			bit_r <= rd_mux[sfr_req_i.bit_sel];
		end
	end
	assign sfr_rdata_o = rdata_r;
	assign sfr_bit_o = bit_r;

	// ----------------------------------------
	// port 1 pin cells
	// ----------------------------------------
	assign port1_bypass_o = {1'b0, bypass_r} & BYPASS_MASK;
	genvar n;
	generate
		for (n = 0; n < PORT1_PINS; n++) begin : g_pin
			wire digital = adsel_r[n] != MODE_ANALOG;
			wire src = port1_xbar_assigned_i[n] ? port1_xbar_dout_i[n]
				: port1_latch_i[n];
			// bus pins forced open-drain; analog pins ignore drive mode
			wire push = digital && p1drv_r[n] == DRV_PUSH_PULL
				&& !port1_smbus_pin_i[n];
			assign port1_ctl_o[n].dout = digital && src;
			assign port1_ctl_o[n].oe = digital && (push || !src);
			assign port1_ctl_o[n].pullup_en = digital;
			assign port1_ctl_o[n].rx_en = digital;
			assign port1_rx_o[n] = digital && port1_pad_i[n];
		end
	endgenerate

	// ----------------------------------------
	// port 2 pin cell
	// ----------------------------------------
	assign port2_ctl_o.dout = p2latch_r;
	assign port2_ctl_o.oe = p2drv_r == DRV_PUSH_PULL || !p2latch_r;
	assign port2_ctl_o.pullup_en = 1'b1;
	assign port2_ctl_o.rx_en = 1'b1;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	analog_off_a: assert property (@(posedge clk_i) disable iff (srst_i)
		adsel_r[0] == MODE_ANALOG |-> !port1_ctl_o[0].oe && !port1_ctl_o[0].pullup_en)
		else $error("analog pin still active");
	analog_ignore_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(adsel_r[1] == MODE_ANALOG && p1drv_r[1]) |-> !port1_ctl_o[1].oe)
		else $error("analog pin drives");
	open_drain_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(adsel_r[2] && !p1drv_r[2] && port1_ctl_o[2].dout) |-> !port1_ctl_o[2].oe)
		else $error("open-drain drives high");
	bypass_top_a: assert property (@(posedge clk_i) disable iff (srst_i)
		!port1_bypass_o[7] && port1_bypass_o[6:0] == bypass_r)
		else $error("bypass bit 7 set");
	bypass_wr_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(wr_byte && hit_bypass) |=> port1_bypass_o == (BYPASS_MASK & $past(sfr_req_i.wdata)))
		else $error("bypass write wrong");
	latch_wr_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(wr_byte && hit_p2) |=> port2_ctl_o.dout == $past(sfr_req_i.wdata[0]))
		else $error("port 2 latch not loaded");
	pin_read_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(ce_i && sfr_req_i.rd && hit_p2) |=> sfr_rdata_o == {7'h00, $past(port2_pad_i)})
		else $error("port 2 read wrong");
	bit_set_a: assert property (@(posedge clk_i) disable iff (srst_i)
		wr_bit0 |=> port2_ctl_o.dout == $past(sfr_req_i.bit_val))
		else $error("bit op lost");
	p2_mode_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(!p2drv_r && port2_ctl_o.dout) |-> !port2_ctl_o.oe)
		else $error("port 2 open-drain drives");
	smbus_od_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(port1_smbus_pin_i[3] && port1_ctl_o[3].dout) |-> !port1_ctl_o[3].oe)
		else $error("bus pin driven high");

	// ----------------------------------------
	// per-pin checks on every port 1 cell
	// ----------------------------------------
	genvar k;
	generate
		for (k = 0; k < PORT1_PINS; k++) begin : g_chk
			// pin placed in analog mode
			sequence pin_analog_s;
				adsel_r[k] == MODE_ANALOG;
			endsequence
			// digital pin set for push-pull and carrying no bus line
			sequence pin_push_s;
				adsel_r[k] != MODE_ANALOG && p1drv_r[k] == DRV_PUSH_PULL
					&& !port1_smbus_pin_i[k];
			endsequence
			// digital pin that may only sink current
			sequence pin_sink_s;
				adsel_r[k] != MODE_ANALOG
					&& (p1drv_r[k] == DRV_OPEN_DRAIN || port1_smbus_pin_i[k]);
			endsequence

			// analog cell: driver, pullup and receiver all dark
			cell_off_a: assert property (@(posedge clk_i) disable iff (srst_i)
				pin_analog_s |-> port1_ctl_o[k] == '0 && !port1_rx_o[k])
				else $error("analog cell not dark");

			// digital cell passes the pad level and keeps its pullup
			rx_follow_a: assert property (@(posedge clk_i) disable iff (srst_i)
				adsel_r[k] != MODE_ANALOG |-> port1_rx_o[k] == port1_pad_i[k]
				&& port1_ctl_o[k].rx_en && port1_ctl_o[k].pullup_en)
				else $error("digital receiver wrong");

			// push-pull cell drives both levels
			push_drive_a: assert property (@(posedge clk_i) disable iff (srst_i)
				pin_push_s |-> port1_ctl_o[k].oe)
				else $error("push-pull pin released");

			// open-drain or bus cell drives only a low
			sink_only_a: assert property (@(posedge clk_i) disable iff (srst_i)
				pin_sink_s |-> port1_ctl_o[k].oe == !port1_ctl_o[k].dout)
				else $error("open-drain pin wrong");

			// unassigned digital pin follows its port latch
			latch_src_a: assert property (@(posedge clk_i) disable iff (srst_i)
				(adsel_r[k] != MODE_ANALOG && !port1_xbar_assigned_i[k])
				|-> port1_ctl_o[k].dout == port1_latch_i[k])
				else $error("latch not on pin");

			// assigned digital pin follows its peripheral
			xbar_src_a: assert property (@(posedge clk_i) disable iff (srst_i)
				(adsel_r[k] != MODE_ANALOG && port1_xbar_assigned_i[k])
				|-> port1_ctl_o[k].dout == port1_xbar_dout_i[k])
				else $error("peripheral not on pin");
		end
	endgenerate

	// ----------------------------------------
	// register access checks
	// ----------------------------------------
	wire rd_take = ce_i && sfr_req_i.rd;

	// input-mode byte write lands whole
	adsel_wr_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(wr_byte && hit_adsel) |=> adsel_r == $past(sfr_req_i.wdata))
		else $error("input-mode write lost");

	// output-mode byte write lands whole
	p1drv_wr_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(wr_byte && hit_p1drv) |=> p1drv_r == $past(sfr_req_i.wdata))
		else $error("output-mode write lost");

	// port 2 mode write keeps only the low bit
	p2drv_wr_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(wr_byte && hit_p2drv) |=> p2drv_r == $past(sfr_req_i.wdata[PORT2_BIT]))
		else $error("port 2 mode write lost");

	// input-mode read returns the register
	adsel_rd_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(rd_take && hit_adsel) |=> sfr_rdata_o == $past(adsel_r))
		else $error("input-mode read wrong");

	// output-mode read returns the register
	p1drv_rd_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(rd_take && hit_p1drv) |=> sfr_rdata_o == $past(p1drv_r))
		else $error("output-mode read wrong");

	// bypass read shows a zero top bit
	bypass_rd_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(rd_take && hit_bypass) |=> !sfr_rdata_o[BYPASS_BITS]
		&& sfr_rdata_o[BYPASS_BITS-1:0] == $past(bypass_r))
		else $error("bypass read wrong");

	// port 2 mode read shows zeros above bit 0
	p2drv_rd_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(rd_take && hit_p2drv) |=> sfr_rdata_o == {7'h00, $past(p2drv_r)})
		else $error("port 2 mode read wrong");

	// bit test of pin 0 returns the pad level
	bit_test_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(rd_take && hit_p2 && sfr_req_i.bit_sel == 3'(PORT2_BIT))
		|=> sfr_bit_o == $past(port2_pad_i))
		else $error("bit test wrong");

	// bit test of an unused port 2 bit gives zero
	upper_zero_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(rd_take && hit_p2 && sfr_req_i.bit_sel != 3'(PORT2_BIT)) |=> !sfr_bit_o)
		else $error("unused bit reads one");

	// a bit write anywhere but pin 0 changes nothing
	bit_guard_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(ce_i && sfr_req_i.wr && sfr_req_i.bit_op && !wr_bit0)
		|=> $stable(p2latch_r) && $stable(adsel_r) && $stable(p1drv_r)
		&& $stable(bypass_r) && $stable(p2drv_r))
		else $error("stray bit write landed");

	// enable low freezes the configuration
	cfg_freeze_a: assert property (@(posedge clk_i) disable iff (srst_i)
		!ce_i |=> $stable(adsel_r) && $stable(p1drv_r) && $stable(bypass_r)
		&& $stable(p2latch_r) && $stable(p2drv_r))
		else $error("state moved while frozen");

	// enable low freezes the read path
	rd_freeze_a: assert property (@(posedge clk_i) disable iff (srst_i)
		!ce_i |=> $stable(rdata_r) && $stable(bit_r))
		else $error("read data moved while frozen");

	// reset leaves input-mode, output-mode, bypass, port 2 latch and read data at their start values
	reset_image_a: assert property (@(posedge clk_i) disable iff (srst_i)
		$past(srst_i) |-> adsel_r == RST_PORT1_ANALOG_DIGITAL_SELECT
		&& p1drv_r == RST_PORT1_OUTPUT_DRIVER_SELECT
		&& bypass_r == RST_PORT1_CROSSBAR_BYPASS[BYPASS_BITS-1:0]
		&& p2latch_r == RST_PORT2_PIN_DATA[PORT2_BIT] && rdata_r == 8'h00)
		else $error("reset value wrong");

	// port 2 push-pull drives the latch level
	p2_push_a: assert property (@(posedge clk_i) disable iff (srst_i)
		p2drv_r == DRV_PUSH_PULL |-> port2_ctl_o.oe && port2_ctl_o.dout == p2latch_r)
		else $error("port 2 push-pull wrong");

	// port 2 open-drain sinks only a low latch
	p2_sink_a: assert property (@(posedge clk_i) disable iff (srst_i)
		p2drv_r == DRV_OPEN_DRAIN |-> port2_ctl_o.oe == !p2latch_r)
		else $error("port 2 open-drain wrong");

	// port 2 receiver stays on so the pin can be read
	p2_rx_a: assert property (@(posedge clk_i) disable iff (srst_i)
		port2_ctl_o.rx_en && port2_ctl_o.pullup_en)
		else $error("port 2 receiver off");
endmodule // port_cfg

// file: test/pad_model.sv
`timescale 1ns/1ns
// pins and crossbar stand-in
module pad_model
	import port_cfg_pkg::*;
(
	input wire port_cfg_pkg::pin_ctl_t [7:0] p1_i,
	input wire port_cfg_pkg::pin_ctl_t p2_i,
	input wire logic [7:0] byp_i,
	input wire logic [7:0] want_i,
	input wire logic [8:0] ext_i,
	output logic [7:0] pad1_o,
	output logic pad2_o,
	output logic [7:0] asg_o
);
	// a released pin shows its pullup or the outside level
	always_comb begin
		for (int n = 0; n < 8; n++)
			pad1_o[n] = p1_i[n].oe ? p1_i[n].dout : (p1_i[n].pullup_en | ext_i[n]);
		pad2_o = p2_i.oe ? p2_i.dout : (p2_i.pullup_en | ext_i[8]);
	end
	// decoder passes over skipped pins
	assign asg_o = want_i & ~byp_i;
endmodule // pad_model

// file: test/port1_port2_pin_config_test.sv
`timescale 1ns/1ns
module port1_port2_pin_config_test;
	import port_cfg_pkg::*;
	logic clk_i = 0, srst_i = 1, ce_i = 1, bitv, pad2;
	sfr_req_t req = '0;
	logic [7:0] rdata, rx1, byp_o, pad1, asg, latch = 0, want = 0, xd = 0, smb = 0;
	logic [7:0] ad, drv, byp, src, d;
	logic [8:0] ext = 0;
	pin_ctl_t [7:0] ctl1;
	pin_ctl_t ctl2;
	int seed = 1, failures = 0, n_tests = 0, cyc = 0;
	always #25 clk_i = ~clk_i;
	port_cfg dut_u (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .sfr_req_i(req),
		.sfr_rdata_o(rdata), .sfr_bit_o(bitv), .port1_latch_i(latch),
		.port1_xbar_assigned_i(asg), .port1_xbar_dout_i(xd), .port1_smbus_pin_i(smb),
		.port1_pad_i(pad1), .port1_ctl_o(ctl1), .port1_rx_o(rx1), .port1_bypass_o(byp_o),
		.port2_pad_i(pad2), .port2_ctl_o(ctl2));
	pad_model pm_u (.p1_i(ctl1), .p2_i(ctl2), .byp_i(byp_o), .want_i(want), .ext_i(ext),
		.pad1_o(pad1), .pad2_o(pad2), .asg_o(asg));
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one register access, answer settled on return
	task acc(input logic w, input logic [7:0] a, input logic [7:0] dv, input logic b = 0);
		@(posedge clk_i) req <= '{wr:w, rd:~w, bit_op:b, bit_sel:3'h0, bit_val:dv[0],
			addr:a, wdata:dv};
		@(posedge clk_i) req <= '0;
		#1;
	endtask
	// expected cell: analog all off, open-drain drives only a low
	function automatic pin_ctl_t pin_exp(logic a, logic pp, logic s);
		pin_exp = '0;
		if (a)
			pin_exp = '{dout:s, oe:pp | ~s, pullup_en:1'b1, rx_en:1'b1};
	endfunction
	task complete_run;
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// hang guard
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			complete_run;
		end
	end
	// main sequence
	initial begin
		repeat (8) @(posedge clk_i);
		srst_i <= 0;
		acc(0, 8'hA5, 0); chk(rdata, 8'h00);
		acc(0, 8'hA6, 0); chk(rdata, 8'h00);
		acc(0, 8'hD5, 0); chk(rdata, 8'h00);
		acc(0, 8'hF2, 0); chk(rdata, 8'hFF);
		acc(0, 8'h10, 0); chk(rdata, 8'h00);
		chk(ctl2.dout, 1);
		for (int i = 0; i < 24; i++) begin
			ad = i == 0 ? 8'h00 : 8'($random(seed));
			drv = i == 0 ? 8'hFF : 8'($random(seed));
			byp = 8'($random(seed));
			acc(1, 8'hF2, ad);
			acc(1, 8'hA5, drv);
			acc(1, 8'hD5, byp);
			{latch, want, xd, smb} <= {$random(seed)};
			ext <= 9'($random(seed));
			#2;
			src = (asg & xd) | (~asg & latch);
			for (int n = 0; n < 8; n++)
				chk(ctl1[n], pin_exp(ad[n], drv[n] & ~smb[n], src[n]));
			chk(rx1, ad & pad1);
			chk(byp_o, byp & 8'h7F);
			acc(0, 8'hD5, 0); chk(rdata, byp & 8'h7F);
			acc(0, 8'hA5, 0); chk(rdata, drv);
		end
		acc(1, 8'hA6, 8'hFF); acc(0, 8'hA6, 0); chk(rdata, 8'h01);
		chk({ctl2.oe, ctl2.dout}, 2'b11);
		for (int i = 0; i < 6; i++) begin
			d = 8'($random(seed));
			acc(1, 8'hA0, d, i[0]);
			chk(ctl2.dout, d[0]);
			acc(0, 8'hA0, 0); chk(rdata, {7'h0, d[0]});
			chk(bitv, d[0]);
		end
		acc(1, 8'hA6, 0); acc(1, 8'hA0, 0); chk({ctl2.oe, ctl2.dout}, 2'b10);
		ce_i <= 0;
		acc(1, 8'hA0, 8'h01);
		ce_i <= 1;
		chk(ctl2.dout, 0);
		complete_run;
	end
endmodule // port1_port2_pin_config_test
